//--- verification/sbnv_link_model.sv
/* link layer stand-in: one-cycle strobes and cycle start arbitration grants.
   assumes the bench calls send right after a rising edge of aclk. */
`timescale 1ns/1ps
module sbnv_link_model (
    input wire logic aclk,
    input wire logic cs_arb_req,
    output sbn_pkg::sbn_link_in_s link_in
);
    import sbn_pkg::*;
    sbn_link_in_s ev_q = '0;
    logic won_q = 1'b0;
    logic req_q = 1'b0;
    always_comb begin
        link_in = ev_q;
        link_in.arb_won = won_q;
    end
    // grant comes a cycle late, as on a bus that is not idle
    always @(posedge aclk) begin
        req_q <= cs_arb_req;
        won_q <= cs_arb_req & req_q & ~won_q;
    end
    // one idle cycle after each strobe, so back-to-back calls never collide
    task automatic send(input sbn_link_in_s v);
        ev_q <= v;
        @(posedge aclk);
        ev_q <= '0;
        @(posedge aclk);
    endtask
endmodule

//--- verification/sbnv_tb.sv
/* self-checking bench of the node register bank.
   assumes the link stand-in module and the constants header. */
`timescale 1ns/1ps
`include "sbn_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    import sbn_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    sbn_axi_req_s req = '0;
    sbn_axi_rsp_s rsp;
    sbn_link_in_s li;
    sbn_link_out_s lo;
    sbn_link_in_s v;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int rst_seen = 0;
    int n;
    logic [31:0] d;
    logic [31:0] t;
    logic [1:0] r;
    logic [5:0] me;
    sbn_csr_node uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .link_in(li), .link_out(lo));
    sbnv_link_model lm (.aclk(aclk), .cs_arb_req(lo.cs_arb_req), .link_in(li));
    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (lo.cmd_reset === 1'b1) rst_seen++;
        if (cyc == 60000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ready lines stay high once raised: legal, and avoids double drives between calls
    task automatic wr(input logic [15:0] a, input logic [31:0] wd);
        req.awaddr <= a;
        req.wdata <= wd;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
    endtask
    task automatic rd(input logic [15:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
    endtask
    task automatic t_reset_vals();
        rd(`SBN_OFF_BW_AVAIL); `CHK(d[12:0], 13'h1333)
        rd(`SBN_OFF_CHAN_HI); `CHK(d, 32'hffff_ffff)
        rd(`SBN_OFF_CHAN_LO); `CHK(d, 32'hffff_ffff)
        rd(`SBN_OFF_MGR_ID); `CHK(d[5:0], 6'h3f)
        rd(`SBN_OFF_SPLIT_HI); `CHK(d, 32'h0000_0001)
        rd(`SBN_OFF_STATE_SET); `CHK(r, 2'h0)
        rd(16'h0ffc); `CHK(r, 2'h2)
        n = rst_seen;
        wr(`SBN_OFF_RESET_START, 32'h0000_0001); `CHK(r, 2'h0)
        repeat (3) @(posedge aclk);
        `CHK(rst_seen, n + 1)
        rd(`SBN_OFF_RESET_START); `CHK(d, 32'h0)
    endtask
    task automatic t_split();
        wr(`SBN_OFF_SPLIT_HI, 32'h0);
        wr(`SBN_OFF_SPLIT_LO, 32'h0008_0000);
        `CHK(lo.split_limit, 16'h0001)
        v = '0;
        v.split_req = 1'b1;
        lm.send(v);
        n = 0;
        // the limit counts isochronous cycles of 5000 aclk each
        while (lo.split_timeout !== 1'b1 && n < 12000) begin
            @(posedge aclk);
            n++;
        end
        `CHK((n >= 5001) && (n <= 10000), 1'b1)
    endtask
    task automatic t_cycle_time();
        rd(`SBN_OFF_CYCLE_TIME);
        t = d;
        rd(`SBN_OFF_CYCLE_TIME); `CHK(d > t, 1'b1)
        v = '0;
        v.cs_rx_valid = 1'b1;
        v.cs_rx_time = 32'h0206_4000;
        lm.send(v);
        rd(`SBN_OFF_CYCLE_TIME); `CHK((d >= 32'h0206_4000) && (d < 32'h0206_4020), 1'b1)
        t = d;
        v.cs_rx_time = 32'h0000_1000;
        lm.send(v);
        rd(`SBN_OFF_CYCLE_TIME); `CHK(d >= t, 1'b1)
        // park just before a cycle count wrap so the bus time step comes quickly
        wr(`SBN_OFF_CYCLE_TIME, 32'h01f3_fbf0);
        repeat (40) @(posedge aclk);
        rd(`SBN_OFF_BUS_TIME); `CHK(d, 32'h0000_0001)
        rd(`SBN_OFF_CYCLE_TIME); `CHK(d[31:12], 20'h02000)
    endtask
    task automatic wait_tx();
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (lo.cs_tx_valid !== 1'b1);
    endtask
    task automatic t_master();
        wr(`SBN_OFF_STATE_SET, 32'h0000_0100);
        wait_tx();
        t = lo.cs_tx_time;
        wait_tx();
        `CHK((n >= 4999) && (n <= 5001), 1'b1)
        `CHK(lo.cs_tx_time[24:12], t[24:12] + 13'h1)
        `CHK(lo.cs_arb_req, 1'b0)
        `CHK(lo.cs_tx_addr, {16'hffff, 48'hffff_f000_0200})
        wr(`SBN_OFF_STATE_CLEAR, 32'h0000_0100);
    endtask
    // two self-id rounds: own phy id is the largest contender, then a smaller one
    task automatic t_irm();
        for (int k = 0; k < 2; k++) begin
            me = k ? 6'h01 : 6'h05;
            if (k) wr(`SBN_OFF_CTRL, 32'h0000_0007);
            v = '0;
            v.bus_reset = 1'b1;
            lm.send(v);
            for (int p = 0; p < 6; p++) begin
                v = '0;
                v.sid_valid = 1'b1;
                v.sid.phy_id = p[5:0];
                v.sid.link_active = 1'b1;
                v.sid.contender = (p == 2) || (p == 5 && k == 0);
                v.sid.power = (p == 3) ? 3'h5 : 3'h0;
                lm.send(v);
            end
            v = '0;
            v.sid_done = 1'b1;
            lm.send(v);
            `CHK(lo.root_reset_req, k[0])
            `CHK(lo.force_root_id, k ? 6'h02 : 6'h05)
            `CHK(lo.gap_update, k[0])
            `CHK(lo.gap_count, k ? 6'h14 : 6'h3f)
            `CHK(lo.shed_valid, k[0])
            v.sid_done = 1'b0;
            v.nid_valid = 1'b1;
            v.nid = {10'h3ff, me};
            lm.send(v);
            `CHK(lo.is_irm, k == 0)
            rd(`SBN_OFF_NODE_ID); `CHK(d, {16'h0000, v.nid})
            rd(`SBN_OFF_MGR_ID); `CHK(d[5:0], k ? 6'h01 : 6'h3f)
        end
        rd(16'h100c); `CHK(d, 32'h0000_01c5)
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_split();
        t_cycle_time();
        t_irm();
        t_master();
        finish_test();
    end
endmodule

//--- verilog/sbn_consts.svh
/*
 * Offsets, reset values and timing counts of the serial bus node register bank.
 * Assumes byte addressing on a 32-bit AXI4-Lite bus, one register per aligned word.
 */
`ifndef SBN_CONSTS_SVH
`define SBN_CONSTS_SVH

`define SBN_INIT_SPACE_BASE 48'hffff_f000_0000
`define SBN_BROADCAST_NODE 16'hffff

`define SBN_OFF_STATE_CLEAR 16'h0000
`define SBN_OFF_STATE_SET 16'h0004
`define SBN_OFF_NODE_ID 16'h0008
`define SBN_OFF_RESET_START 16'h000c
`define SBN_OFF_SPLIT_HI 16'h0018
`define SBN_OFF_SPLIT_LO 16'h001c
`define SBN_OFF_CYCLE_TIME 16'h0200
`define SBN_OFF_BUS_TIME 16'h0204
`define SBN_OFF_BUSY_TIMEOUT 16'h0210
`define SBN_OFF_MGR_ID 16'h021c
`define SBN_OFF_BW_AVAIL 16'h0220
`define SBN_OFF_CHAN_HI 16'h0224
`define SBN_OFF_CHAN_LO 16'h0228
`define SBN_OFF_CTRL 16'h0300
`define SBN_OFF_STATUS 16'h0304
`define SBN_OFF_GAP 16'h0308
`define SBN_WIN_TOPO 8'h10
`define SBN_WIN_SPEED 8'h11

`define SBN_STATE_CMSTR_BIT 8
`define SBN_CTRL_BM_BIT 0
`define SBN_CTRL_ISO_BIT 1
`define SBN_CTRL_GAP_BIT 2

`define SBN_RST_BW 13'h1333
`define SBN_RST_CHAN 64'hffff_ffff_ffff_ffff
`define SBN_RST_MGR_ID 6'h3f
`define SBN_RST_NODE_ID 16'hffff
`define SBN_RST_SPLIT_HI 32'h0000_0001
`define SBN_RST_SPLIT_LO 32'h0000_0000
`define SBN_RST_BUSY 32'h0000_0000
`define SBN_RST_GAP 6'h3f

`define SBN_SYS_CLK_KHZ 40000
`define SBN_CYC_CLK_KHZ 24576
`define SBN_CYCLES_PER_SEC 8000
`define SBN_CYCLE_PERIOD_US 125
`define SBN_OFFSET_MAX (`SBN_CYC_CLK_KHZ * `SBN_CYCLE_PERIOD_US / 1000 - 1)
`define SBN_CYCLE_MAX (`SBN_CYCLES_PER_SEC - 1)

`define SBN_GAP_BASE 6'h05
`define SBN_GAP_PER_HOP 6'h03

`endif

//--- verilog/sbn_csr_node.sv
/*
 * Serial bus node register bank with cycle clock, cycle master, resource
 * manager and bus manager duties, reached by software over AXI4-Lite.
 * Assumes a 40 MHz aclk and a link layer that delivers self-identify
 * quadlets, cycle start packets and arbitration results as one-cycle strobes.
 */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
// What this block does
// - core registers live in initial register space
// - state clear and set registers always present
// - node identity loaded after each bus reset
// - write to reset start forces command reset
// - split transactions time out at programmed limit
// - free-running cycle clock readable as cycle time
// - received cycle start loads cycle time when not cycle master and not behind current time
// - cycle time never moves backward except on a software write
// - cycle master makes 8000 cycle events per second
// - cycle master arbitrates then sends cycle start
// - bus time register extends the clock range
// - available bandwidth starts near 100 microseconds
// - 64-bit channel map, all free initially
// - manager pointer register, written by bus manager
// - largest contender physical id becomes resource manager
// - resource manager and cycle master both provided
// - bus manager resets bus for capable root
// - bus manager publishes topology and speed maps
// - bus manager may shrink the gap count
// - bus manager sheds nodes on power overrun
// - bus address is node id plus offset
`timescale 1ns/1ps
`include "sbn_consts.svh"

module sbn_csr_node (
    input wire logic aclk,
    input wire logic aresetn,
    input wire sbn_pkg::sbn_axi_req_s axi_req,
    output sbn_pkg::sbn_axi_rsp_s axi_rsp,
    input wire sbn_pkg::sbn_link_in_s link_in,
    output sbn_pkg::sbn_link_out_s link_out
);
    import sbn_pkg::*;

    sbn_state_s s_q;
    sbn_state_s s_d;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // offset, cycle count, seconds; the counting order of the cycle clock
    function automatic logic [31:0] ct_next(input logic [31:0] ct);
        logic [31:0] n;
        n = ct;
        if (ct[11:0] >= 12'(`SBN_OFFSET_MAX)) begin
            n[11:0] = 12'h000;
            if (ct[24:12] >= 13'(`SBN_CYCLE_MAX)) begin
                n[24:12] = 13'h0000;
                n[31:25] = ct[31:25] + 7'h01;
            end else begin
                n[24:12] = ct[24:12] + 13'h0001;
            end
        end else begin
            n[11:0] = ct[11:0] + 12'h001;
        end
        return n;
    endfunction

    logic wr_go;
    logic tick;
    logic [16:0] acc_sum;
    logic cyc_wrap;
    logic off_wrap;
    logic cm_en;
    logic [31:0] rd_val;
    logic rd_ok;
    logic [15:0] limit;
    logic [2:0] units;
    logic [5:0] hops;

    always_comb begin
        s_d = s_q;
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        cm_en = s_q.state_bits[`SBN_STATE_CMSTR_BIT];
        s_d.wr_done = 1'b0;
        s_d.cmd_reset = 1'b0;
        s_d.cs_tx = 1'b0;
        s_d.split_to = 1'b0;
        s_d.gap_upd = 1'b0;
        s_d.root_req = 1'b0;
        s_d.shed = 1'b0;
        units = 3'h0;
        hops = 6'h00;

        // free-running cycle clock from the 40 MHz system clock
        acc_sum = {1'b0, s_q.tick_acc} + 17'(`SBN_CYC_CLK_KHZ);
        tick = acc_sum >= 17'(`SBN_SYS_CLK_KHZ);
        s_d.tick_acc = tick ? 16'(acc_sum - 17'(`SBN_SYS_CLK_KHZ)) : acc_sum[15:0];
        off_wrap = tick && (s_q.cycle_time[11:0] >= 12'(`SBN_OFFSET_MAX));
        cyc_wrap = off_wrap && (s_q.cycle_time[24:12] >= 13'(`SBN_CYCLE_MAX));
        if (tick) begin
            s_d.cycle_time = ct_next(s_q.cycle_time);
        end
        if (cyc_wrap) begin
            s_d.bus_time = s_q.bus_time + 32'h0000_0001;
        end
        // a late cycle start is ignored rather than stepping time back
        if (link_in.cs_rx_valid && !cm_en
            && $signed(link_in.cs_rx_time - s_q.cycle_time) >= 0) begin
            s_d.cycle_time = link_in.cs_rx_time;
        end

        // cycle master: one event per cycle count step, i.e. 8000 per second
        case (s_q.cm)
            CM_IDLE: begin
                if (cm_en && off_wrap) begin
                    s_d.cm = CM_ARB;
                end
            end
            CM_ARB: begin
                if (link_in.arb_won) begin
                    s_d.cs_tx = 1'b1;
                    s_d.cm = CM_IDLE;
                end
            end
            default: s_d.cm = CM_IDLE;
        endcase

        // split transaction timer counts isochronous cycles
        limit = 16'(s_q.split_hi[2:0] * 16'(`SBN_CYCLES_PER_SEC)) + 16'(s_q.split_lo[31:19]);
        if (link_in.split_req) begin
            s_d.split_busy = 1'b1;
            s_d.split_cnt = 16'h0000;
        end else if (link_in.split_resp) begin
            s_d.split_busy = 1'b0;
        end else if (s_q.split_busy && off_wrap) begin
            if (s_q.split_cnt >= limit) begin
                s_d.split_to = 1'b1;
                s_d.split_busy = 1'b0;
            end else begin
                s_d.split_cnt = s_q.split_cnt + 16'h0001;
            end
        end

        // node identity and self-identify analysis
        if (link_in.bus_reset) begin
            s_d.node_id = `SBN_RST_NODE_ID;
            s_d.mgr_id = `SBN_RST_MGR_ID;
            s_d.max_id = 6'h00;
            s_d.max_cont = 6'h00;
            s_d.cont_seen = 1'b0;
            s_d.root_cap = 1'b0;
            s_d.nodes = 7'h00;
            s_d.demand = 8'h00;
            s_d.supply = 8'h00;
        end
        if (link_in.nid_valid) begin
            s_d.node_id = link_in.nid;
            // own id is only known from the node id strobe, after self-id ends
            if (s_q.ctrl[`SBN_CTRL_BM_BIT]) begin
                s_d.mgr_id = link_in.nid[5:0];
            end
        end
        if (link_in.sid_valid) begin
            s_d.topo[link_in.sid.phy_id] = 32'(link_in.sid);
            s_d.nodes = s_q.nodes + 7'h01;
            if (link_in.sid.phy_id >= s_q.max_id) begin
                s_d.max_id = link_in.sid.phy_id;
                s_d.root_cap = link_in.sid.contender; // highest id is the root
            end
            if (link_in.sid.contender && link_in.sid.phy_id >= s_q.max_cont) begin
                s_d.max_cont = link_in.sid.phy_id;
                s_d.cont_seen = 1'b1;
            end
            units = {1'b0, link_in.sid.power[1:0]} + 3'h1;
            if (link_in.sid.power[2]) begin
                s_d.demand = s_q.demand + 8'(units);
                s_d.shed_id = link_in.sid.phy_id;
            end else if (link_in.sid.power[1:0] != 2'b00) begin
                s_d.supply = s_q.supply + 8'(units);
            end
        end
        if (link_in.sid_done && s_q.ctrl[`SBN_CTRL_BM_BIT]) begin
            s_d.power_over = s_q.demand > s_q.supply;
            s_d.shed = s_q.demand > s_q.supply;
            if (s_q.ctrl[`SBN_CTRL_ISO_BIT] && !s_q.root_cap) begin
                s_d.root_req = 1'b1;
            end
            // daisy chain is the worst case: hops bounded by node count
            hops = (s_q.nodes > 7'h01) ? 6'(s_q.nodes - 7'h01) : 6'h00;
            if (s_q.ctrl[`SBN_CTRL_GAP_BIT] && hops < 6'h12) begin
                s_d.gap = `SBN_GAP_BASE + 6'(hops * `SBN_GAP_PER_HOP);
                s_d.gap_upd = 1'b1;
            end
        end

        // register read decode
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        if (axi_req.araddr[15:8] == `SBN_WIN_TOPO) begin
            rd_val = s_q.topo[axi_req.araddr[7:2]];
        end else if (axi_req.araddr[15:8] == `SBN_WIN_SPEED) begin
            rd_val = {30'h0, s_q.topo[axi_req.araddr[7:2]][5:4]};
        end else begin
            case (axi_req.araddr)
                `SBN_OFF_STATE_CLEAR: rd_val = s_q.state_bits;
                `SBN_OFF_STATE_SET: rd_val = s_q.state_bits;
                `SBN_OFF_NODE_ID: rd_val = {16'h0000, s_q.node_id};
                `SBN_OFF_RESET_START: rd_val = 32'h0000_0000;
                `SBN_OFF_SPLIT_HI: rd_val = s_q.split_hi;
                `SBN_OFF_SPLIT_LO: rd_val = s_q.split_lo;
                `SBN_OFF_CYCLE_TIME: rd_val = s_q.cycle_time;
                `SBN_OFF_BUS_TIME: rd_val = s_q.bus_time;
                `SBN_OFF_BUSY_TIMEOUT: rd_val = s_q.busy_timeout;
                `SBN_OFF_MGR_ID: rd_val = {26'h0, s_q.mgr_id};
                `SBN_OFF_BW_AVAIL: rd_val = {19'h0, s_q.bw_avail};
                `SBN_OFF_CHAN_HI: rd_val = s_q.chan_avail[63:32];
                `SBN_OFF_CHAN_LO: rd_val = s_q.chan_avail[31:0];
                `SBN_OFF_CTRL: rd_val = {29'h0, s_q.ctrl};
                `SBN_OFF_STATUS: rd_val = {26'h0, s_q.power_over, s_q.root_cap,
                                           s_q.cont_seen, link_out.is_irm,
                                           s_q.split_busy, s_q.cm == CM_ARB};
                `SBN_OFF_GAP: rd_val = {26'h0, s_q.gap};
                default: rd_ok = 1'b0;
            endcase
        end
        if (axi_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_ok ? 2'b00 : 2'b10;
        end else if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end

        // write path: address and data taken in either order
        if (axi_req.awvalid && !s_q.aw_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_have && !s_q.bvalid) begin
            s_d.w_have = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = 2'b00;
            s_d.wr_done = 1'b1;
            s_d.wr_addr = s_q.aw_addr;
            case (s_q.aw_addr)
                `SBN_OFF_STATE_CLEAR: s_d.state_bits = s_q.state_bits
                                          & ~(s_q.w_data & merge(32'h0, 32'hffff_ffff, s_q.w_strb));
                `SBN_OFF_STATE_SET: s_d.state_bits = s_q.state_bits
                                        | (s_q.w_data & merge(32'h0, 32'hffff_ffff, s_q.w_strb));
                `SBN_OFF_NODE_ID: s_d.node_id = 16'(merge({16'h0, s_q.node_id}, s_q.w_data,
                                                          s_q.w_strb));
                `SBN_OFF_RESET_START: begin
                    // command reset returns state bits, split timeout registers and cycle master to defaults
                    s_d.cmd_reset = 1'b1;
                    s_d.state_bits = 32'h0000_0000;
                    s_d.split_hi = `SBN_RST_SPLIT_HI;
                    s_d.split_lo = `SBN_RST_SPLIT_LO;
                    s_d.split_busy = 1'b0;
                    s_d.cm = CM_IDLE;
                end
                `SBN_OFF_SPLIT_HI: s_d.split_hi = merge(s_q.split_hi, s_q.w_data, s_q.w_strb);
                `SBN_OFF_SPLIT_LO: s_d.split_lo = merge(s_q.split_lo, s_q.w_data, s_q.w_strb);
                `SBN_OFF_CYCLE_TIME: s_d.cycle_time = merge(s_q.cycle_time, s_q.w_data,
                                                            s_q.w_strb);
                `SBN_OFF_BUS_TIME: s_d.bus_time = merge(s_q.bus_time, s_q.w_data, s_q.w_strb);
                `SBN_OFF_BUSY_TIMEOUT: s_d.busy_timeout = merge(s_q.busy_timeout, s_q.w_data,
                                                                s_q.w_strb);
                `SBN_OFF_MGR_ID: s_d.mgr_id = s_q.w_data[5:0];
                `SBN_OFF_BW_AVAIL: s_d.bw_avail = s_q.w_data[12:0];
                `SBN_OFF_CHAN_HI: s_d.chan_avail[63:32] = merge(s_q.chan_avail[63:32],
                                                                s_q.w_data, s_q.w_strb);
                `SBN_OFF_CHAN_LO: s_d.chan_avail[31:0] = merge(s_q.chan_avail[31:0],
                                                               s_q.w_data, s_q.w_strb);
                `SBN_OFF_CTRL: s_d.ctrl = s_q.w_data[2:0];
                `SBN_OFF_GAP: s_d.gap = s_q.w_data[5:0];
                default: s_d.bresp = 2'b10;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.cm <= CM_IDLE;
            s_q.node_id <= `SBN_RST_NODE_ID;
            s_q.split_hi <= `SBN_RST_SPLIT_HI;
            s_q.split_lo <= `SBN_RST_SPLIT_LO;
            s_q.busy_timeout <= `SBN_RST_BUSY;
            s_q.mgr_id <= `SBN_RST_MGR_ID;
            s_q.bw_avail <= `SBN_RST_BW;
            s_q.chan_avail <= `SBN_RST_CHAN;
            s_q.gap <= `SBN_RST_GAP;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        axi_rsp.awready = !s_q.aw_have && !s_q.bvalid;
        axi_rsp.wready = !s_q.w_have && !s_q.bvalid;
        axi_rsp.bvalid = s_q.bvalid;
        axi_rsp.bresp = s_q.bresp;
        axi_rsp.arready = !s_q.rvalid;
        axi_rsp.rvalid = s_q.rvalid;
        axi_rsp.rdata = s_q.rdata;
        axi_rsp.rresp = s_q.rresp;
        link_out.cs_arb_req = s_q.cm == CM_ARB;
        link_out.cs_tx_valid = s_q.cs_tx;
        link_out.cs_tx_time = s_q.cycle_time;
        link_out.cs_tx_addr.node_id = `SBN_BROADCAST_NODE;
        link_out.cs_tx_addr.offset = `SBN_INIT_SPACE_BASE + 48'(`SBN_OFF_CYCLE_TIME);
        link_out.cmd_reset = s_q.cmd_reset;
        link_out.split_timeout = s_q.split_to;
        link_out.split_limit = 16'(s_q.split_hi[2:0] * 16'(`SBN_CYCLES_PER_SEC))
                               + 16'(s_q.split_lo[31:19]);
        link_out.root_reset_req = s_q.root_req;
        link_out.force_root_id = s_q.max_cont;
        link_out.gap_count = s_q.gap;
        link_out.gap_update = s_q.gap_upd;
        link_out.shed_valid = s_q.shed;
        link_out.shed_id = s_q.shed_id;
        link_out.is_irm = s_q.cont_seen && s_q.max_cont == s_q.node_id[5:0];
    end

    property p_reset_cmd;
        @(posedge aclk) disable iff (!aresetn)
        ($rose(s_q.wr_done) && s_q.wr_addr == `SBN_OFF_RESET_START) |-> s_q.cmd_reset;
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset start write lost");

    property p_no_backward;
        @(posedge aclk) disable iff (!aresetn)
        !(s_q.wr_done && s_q.wr_addr == `SBN_OFF_CYCLE_TIME) && !$past(s_q.cs_tx)
        |-> $signed(s_q.cycle_time - $past(s_q.cycle_time)) >= 0;
    endproperty
    a_no_backward: assert property (p_no_backward) else $error("cycle time went back");

    property p_cycle_event;
        @(posedge aclk) disable iff (!aresetn)
        (s_q.cm == CM_IDLE && cm_en && off_wrap && !wr_go) |=> link_out.cs_arb_req;
    endproperty
    a_cycle_event: assert property (p_cycle_event) else $error("no cycle event");

    property p_cs_send;
        @(posedge aclk) disable iff (!aresetn)
        (link_out.cs_arb_req && link_in.arb_won) |=> link_out.cs_tx_valid ##1 !link_out.cs_tx_valid;
    endproperty
    a_cs_send: assert property (p_cs_send) else $error("cycle start not sent");

    property p_bw_init;
        @(posedge aclk) $rose(aresetn) |-> s_q.bw_avail == `SBN_RST_BW;
    endproperty
    a_bw_init: assert property (p_bw_init) else $error("bandwidth reset value");

    property p_chan_init;
        @(posedge aclk) $rose(aresetn) |-> s_q.chan_avail == `SBN_RST_CHAN;
    endproperty
    a_chan_init: assert property (p_chan_init) else $error("channel map reset value");

    property p_nid_load;
        @(posedge aclk) disable iff (!aresetn)
        (link_in.nid_valid && !wr_go) |=> s_q.node_id == $past(link_in.nid);
    endproperty
    a_nid_load: assert property (p_nid_load) else $error("node id not loaded");

    property p_split_to;
        @(posedge aclk) disable iff (!aresetn)
        link_out.split_timeout |-> $past(s_q.split_cnt) >= $past(link_out.split_limit);
    endproperty
    a_split_to: assert property (p_split_to) else $error("early split timeout");

    property p_offset_range;
        @(posedge aclk) disable iff (!aresetn)
        (tick && s_q.cycle_time[11:0] == 12'hbff && !wr_go && !link_in.cs_rx_valid)
        |=> s_q.cycle_time[11:0] == 12'h000;
    endproperty
    a_offset_range: assert property (p_offset_range) else $error("offset wrap wrong");
endmodule

//--- verilog/sbn_pkg.sv
/*
 * Types of the serial bus node register bank: bus carriers, link carriers, state.
 * Assumes the constants header is included by every user.
 */
package sbn_pkg;
    typedef enum {CM_IDLE, CM_ARB} sbn_cm_e;

    typedef struct packed {
        logic [15:0] node_id;
        logic [47:0] offset;
    } sbn_bus_addr_s;

    typedef struct packed {
        logic awvalid; logic [15:0] awaddr;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [15:0] araddr;
        logic rready;
    } sbn_axi_req_s;

    typedef struct packed {
        logic awready; logic wready;
        logic bvalid; logic [1:0] bresp;
        logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } sbn_axi_rsp_s;

    typedef struct packed {
        logic [5:0] phy_id; logic link_active; logic [1:0] speed;
        logic contender; logic [2:0] power;
    } sbn_selfid_s;

    typedef struct packed {
        logic bus_reset; logic nid_valid; logic [15:0] nid;
        logic cs_rx_valid; logic [31:0] cs_rx_time;
        logic sid_valid; sbn_selfid_s sid; logic sid_done;
        logic arb_won; logic split_req; logic split_resp;
    } sbn_link_in_s;

    typedef struct packed {
        logic cs_arb_req; logic cs_tx_valid; logic [31:0] cs_tx_time;
        sbn_bus_addr_s cs_tx_addr;
        logic cmd_reset; logic split_timeout; logic [15:0] split_limit;
        logic root_reset_req; logic [5:0] force_root_id;
        logic [5:0] gap_count; logic gap_update;
        logic shed_valid; logic [5:0] shed_id; logic is_irm;
    } sbn_link_out_s;

    typedef struct packed {
        logic aw_have; logic [15:0] aw_addr;
        logic w_have; logic [31:0] w_data; logic [3:0] w_strb;
        logic bvalid; logic [1:0] bresp; logic wr_done; logic [15:0] wr_addr;
        logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
        logic [31:0] state_bits; logic [15:0] node_id;
        logic [31:0] split_hi; logic [31:0] split_lo;
        logic [31:0] cycle_time; logic [31:0] bus_time; logic [31:0] busy_timeout;
        logic [5:0] mgr_id; logic [12:0] bw_avail; logic [63:0] chan_avail;
        logic [2:0] ctrl; logic [15:0] tick_acc; sbn_cm_e cm;
        logic cs_tx; logic cmd_reset;
        logic split_busy; logic [15:0] split_cnt; logic split_to;
        logic [5:0] max_id; logic [5:0] max_cont; logic cont_seen; logic root_cap;
        logic [6:0] nodes; logic [7:0] demand; logic [7:0] supply;
        logic [5:0] shed_id; logic power_over; logic shed;
        logic [5:0] gap; logic gap_upd; logic root_req;
        logic [63:0][31:0] topo;
    } sbn_state_s;
endpackage
